// file: rtcc_consts.vh
// Constants shared by the clock control block: offsets, fields, resets, timing
// What this block does
// - Control bit 7 starts or stops counting
// - Format bit 0 counts hours 0 to 11
// - Format bit 1 counts hours 0 to 23
// - Soft reset bit 4 clears all but itself
// - Timing bit 0 raises periodic events during busy
// - Timing bit 1 raises events after busy ends
// - Control two bit 2 gates one-second event
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH

// Register indices; the byte address is four times the index
`define RTCC_CTRL1_IDX     20'h0f06c
`define RTCC_CTRL2_IDX     20'h0f06d
`define RTCC_CTRL1_ADDR    20'h3c1b0
`define RTCC_CTRL2_ADDR    20'h3c1b4
// Added registers: time readback, event status, clear, enable
`define RTCC_TIME_ADDR     20'h3c1c0
`define RTCC_STAT_ADDR     20'h3c1c4
`define RTCC_CLR_ADDR      20'h3c1c8
`define RTCC_IEN_ADDR      20'h3c1cc

// Field positions in control register one
`define RTCC_RUN_BIT       7
`define RTCC_FMT_BIT       6
`define RTCC_SRST_BIT      4
`define RTCC_ITIM_BIT      3
// Field position in control register two
`define RTCC_OSE_BIT       2

// Reset values
`define RTCC_CTRL1_RST     8'h00
`define RTCC_CTRL2_RST     8'h00
`define RTCC_EVT_RST       4'h0

// Counter limits
`define RTCC_SEC_MAX       6'h3b
`define RTCC_MIN_MAX       6'h3b
`define RTCC_HR12_MAX      5'h0b
`define RTCC_HR24_MAX      5'h17
`define RTCC_DOW_MAX       3'h6

// Timing: clock period, one second, busy period
`define RTCC_CLK_NS        4
`define RTCC_SEC_NS        1000000000
`define RTCC_BUSY_NS       40
`define RTCC_BUSY_CYC      ((`RTCC_BUSY_NS + `RTCC_CLK_NS - 1) / `RTCC_CLK_NS)
`define RTCC_SEC_CYC       (`RTCC_SEC_NS / `RTCC_CLK_NS)

`endif

// file: rtcc_wrap_cnt.v
// Wrapping time counter used for seconds, minutes, hours and weekday
`timescale 1ns/100ps
`default_nettype none

module rtcc_wrap_cnt #(
	parameter W = 6
) (
	input  wire         core_clk,
	input  wire         arst_n,
	input  wire         clr,
	input  wire         inc,
	input  wire [W-1:0] max_val,
	output reg  [W-1:0] cnt_q,
	output wire         wrap
);

	// Wraps at or above the limit, so a shrunk limit is safe
	assign wrap = inc & (cnt_q >= max_val);

	// Count register; clear has priority over increment
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= {W{1'b0}};
		end
		else if (clr)
		begin
			cnt_q <= {W{1'b0}};
		end
		else if (wrap)
		begin
			cnt_q <= {W{1'b0}};
		end
		else if (inc)
		begin
			cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

// file: rtcc_ctrl.v
// Clock control block: APB registers, time counting, periodic events
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_consts.vh"

module rtcc_ctrl #(
	parameter [31:0] SEC_CYC  = `RTCC_SEC_CYC,
	parameter [7:0]  BUSY_CYC = `RTCC_BUSY_CYC
) (
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [19:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         irq
);

	// Control register one fields
	reg        run_q;          // Counting enabled
	reg        fmt_q;          // Hour format, one for 24-hour
	reg        srst_q;         // Soft reset held
	reg        itim_q;         // Event timing select
	// Control register two field
	reg        ose_q;          // One-second event enable
	// Interrupt registers
	reg  [3:0] stat_q;         // Sticky events: sec, min, hour, weekday
	reg  [3:0] ien_q;          // Interrupt enables
	// Timing state
	reg  [31:0] pre_q;         // Prescaler toward one second
	reg  [7:0]  busy_q;        // Busy period cycles left
	reg  [3:0]  pend_q;        // Events waiting for busy end
	// Counter outputs
	wire [5:0] sec_val;        // Seconds
	wire [5:0] min_val;        // Minutes
	wire [4:0] hr_val;         // Hours
	wire [2:0] dow_val;        // Day of week
	wire       sec_wrap;       // Seconds roll over
	wire       min_wrap;       // Minutes roll over
	wire       hr_wrap;        // Hours roll over
	// Bus decode
	wire       acc;            // Access phase awaiting answer
	wire       wr;             // Write taking effect
	wire       hit_c1;         // Control one selected
	wire       hit_c2;         // Control two selected
	wire       hit_tm;         // Time readback selected
	wire       hit_st;         // Status selected
	wire       hit_cl;         // Clear selected
	wire       hit_ie;         // Enable selected
	wire       mapped;         // Any register selected
	// Timing decode
	wire       tick;           // One second elapsed
	wire [3:0] evt_raw;        // Events of this tick
	wire [3:0] evt_now;        // Events raised this cycle
	wire       busy_end;       // Last busy cycle
	wire [4:0] hr_max;         // Hour limit for the format
	reg  [31:0] rd_mux;        // Read data selection
	// Reset values of the two control registers, sized to pick fields
	localparam [7:0] C1_RST = `RTCC_CTRL1_RST;
	localparam [7:0] C2_RST = `RTCC_CTRL2_RST;

	// Access phase; answered one cycle after penable rises
	assign acc    = psel & penable & ~pready;
	assign wr     = acc & pwrite;
	assign hit_c1 = (paddr == `RTCC_CTRL1_ADDR);
	assign hit_c2 = (paddr == `RTCC_CTRL2_ADDR);
	assign hit_tm = (paddr == `RTCC_TIME_ADDR);
	assign hit_st = (paddr == `RTCC_STAT_ADDR);
	assign hit_cl = (paddr == `RTCC_CLR_ADDR);
	assign hit_ie = (paddr == `RTCC_IEN_ADDR);
	assign mapped = hit_c1 | hit_c2 | hit_tm | hit_st | hit_cl | hit_ie;

	// Control register one; a soft reset zeroes the other bits
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			run_q  <= C1_RST[`RTCC_RUN_BIT];
			fmt_q  <= C1_RST[`RTCC_FMT_BIT];
			srst_q <= C1_RST[`RTCC_SRST_BIT];
			itim_q <= C1_RST[`RTCC_ITIM_BIT];
		end
		else if (wr && hit_c1)
		begin
			srst_q <= pwdata[`RTCC_SRST_BIT];
			if (pwdata[`RTCC_SRST_BIT])
			begin
				// Entering or staying in soft reset
				run_q  <= 1'b0;
				fmt_q  <= 1'b0;
				itim_q <= 1'b0;
			end
			else
			begin
				// Normal write
				run_q  <= pwdata[`RTCC_RUN_BIT];
				fmt_q  <= pwdata[`RTCC_FMT_BIT];
				itim_q <= pwdata[`RTCC_ITIM_BIT];
			end
		end
	end

	// Control register two; cleared by soft reset
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ose_q <= C2_RST[`RTCC_OSE_BIT];
		end
		else if (srst_q)
		begin
			ose_q <= 1'b0;
		end
		else if (wr && hit_c2)
		begin
			ose_q <= pwdata[`RTCC_OSE_BIT];
		end
	end

	// Prescaler; frozen while stopped, cleared by soft reset
	assign tick = run_q & ~srst_q & (pre_q == SEC_CYC - 32'h00000001);

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pre_q <= 32'h00000000;
		end
		else if (srst_q || tick)
		begin
			pre_q <= 32'h00000000;
		end
		else if (run_q)
		begin
			pre_q <= pre_q + 32'h00000001;
		end
	end

	// Hour limit by format
	assign hr_max = fmt_q ? `RTCC_HR24_MAX : `RTCC_HR12_MAX;

	// Seconds counter
	rtcc_wrap_cnt #(
		.W(6)
	) u_sec (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.clr      (srst_q),
		.inc      (tick),
		.max_val  (`RTCC_SEC_MAX),
		.cnt_q    (sec_val),
		.wrap     (sec_wrap)
	);

	// Minutes counter
	rtcc_wrap_cnt #(
		.W(6)
	) u_min (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.clr      (srst_q),
		.inc      (sec_wrap),
		.max_val  (`RTCC_MIN_MAX),
		.cnt_q    (min_val),
		.wrap     (min_wrap)
	);

	// Hours counter, wraps at 11 or 23
	rtcc_wrap_cnt #(
		.W(5)
	) u_hr (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.clr      (srst_q),
		.inc      (min_wrap),
		.max_val  (hr_max),
		.cnt_q    (hr_val),
		.wrap     (hr_wrap)
	);

	// Day-of-week counter; in 12-hour mode it steps every hour wrap
	rtcc_wrap_cnt #(
		.W(3)
	) u_dow (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.clr      (srst_q),
		.inc      (hr_wrap),
		.max_val  (`RTCC_DOW_MAX),
		.cnt_q    (dow_val),
		.wrap     ()                // Week roll over raises no event
	);

	// Events of this tick; second event gated by its enable
	assign evt_raw = {hr_wrap, min_wrap, sec_wrap, tick & ose_q};

	// Busy period starts with each tick
	assign busy_end = (busy_q == 8'h01);

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy_q <= 8'h00;
		end
		else if (srst_q)
		begin
			busy_q <= 8'h00;
		end
		else if (tick)
		begin
			busy_q <= BUSY_CYC;
		end
		else if (busy_q != 8'h00)
		begin
			busy_q <= busy_q - 8'h01;
		end
	end

	// Events held for release after busy
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_q <= `RTCC_EVT_RST;
		end
		else if (srst_q)
		begin
			pend_q <= `RTCC_EVT_RST;
		end
		else if (tick && itim_q)
		begin
			pend_q <= evt_raw;
		end
		else if (busy_end)
		begin
			pend_q <= `RTCC_EVT_RST;
		end
	end

	// Raise at tick, or at busy end when delayed timing chosen
	assign evt_now = itim_q ? (busy_end ? pend_q : 4'h0)
	                        : evt_raw;

	// Sticky status; set wins over a clear in the same cycle
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stat_q <= `RTCC_EVT_RST;
		end
		else if (srst_q)
		begin
			stat_q <= `RTCC_EVT_RST;
		end
		else if (wr && hit_cl)
		begin
			stat_q <= (stat_q & ~pwdata[3:0]) | evt_now;
		end
		else
		begin
			stat_q <= stat_q | evt_now;
		end
	end

	// Interrupt enable register
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ien_q <= `RTCC_EVT_RST;
		end
		else if (srst_q)
		begin
			ien_q <= `RTCC_EVT_RST;
		end
		else if (wr && hit_ie)
		begin
			ien_q <= pwdata[3:0];
		end
	end

	// Level interrupt from a flop
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(stat_q & ien_q);
		end
	end

	// Read data selection; clear register reads zero
	always @*
	begin
		rd_mux = 32'h00000000;
		if (hit_c1)
		begin
			rd_mux[`RTCC_RUN_BIT]  = run_q;
			rd_mux[`RTCC_FMT_BIT]  = fmt_q;
			rd_mux[`RTCC_SRST_BIT] = srst_q;
			rd_mux[`RTCC_ITIM_BIT] = itim_q;
		end
		else if (hit_c2)
		begin
			rd_mux[`RTCC_OSE_BIT] = ose_q;
		end
		else if (hit_tm)
		begin
			rd_mux = {5'h00, dow_val, 3'h0, hr_val, 2'h0, min_val, 2'h0, sec_val};
		end
		else if (hit_st)
		begin
			rd_mux[3:0] = stat_q;
		end
		else if (hit_ie)
		begin
			rd_mux[3:0] = ien_q;
		end
	end

	// APB answer: one wait state, error on unmapped address
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else if (acc)
		begin
			pready  <= 1'b1;
			pslverr <= ~mapped;
			prdata  <= pwrite ? 32'h00000000 : rd_mux;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// file: rtcc_ctrl_asserts.sv
// Bus, readback and interrupt checks for the clock control block
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_consts.vh"

module rtcc_ctrl_asserts #(
	parameter [31:0] SEC_CYC  = 20,
	parameter [7:0]  BUSY_CYC = 4
) (
	input wire        core_clk,
	input wire        arst_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [19:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        irq
);
	wire       take;  // Request taken at this edge
	wire       wc1;   // Write to control one taken
	wire       map;   // Address is a register
	reg  [7:0] c1_q;  // Expected control one readback
	assign take = psel && penable && !pready;
	assign wc1 = take && pwrite && paddr == `RTCC_CTRL1_ADDR;
	assign map = paddr == `RTCC_CTRL1_ADDR || paddr == `RTCC_CTRL2_ADDR
		|| paddr == `RTCC_TIME_ADDR || paddr == `RTCC_STAT_ADDR
		|| paddr == `RTCC_CLR_ADDR || paddr == `RTCC_IEN_ADDR;
	// Soft reset keeps only its own bit; otherwise run, format, timing
	always @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			c1_q <= 8'h00;
		else if (wc1)
			c1_q <= pwdata[4] ? 8'h10 : (pwdata[7:0] & 8'hc8);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_ready_follows: assert property (take |=> pready)
		else $error("no answer after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_ready_cause: assert property (pready |-> $past(take))
		else $error("answer without request");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error outside answer");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_unmapped_err: assert property (take && !map |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (take && map |=> !pslverr)
		else $error("register access refused");
	a_ctrl1_read: assert property (
		take && !pwrite && paddr == `RTCC_CTRL1_ADDR |=> prdata == {24'h0, c1_q})
		else $error("control one readback wrong");
	// Status clears one edge after the write, and irq lags status by one more
	a_srst_quiet: assert property (wc1 && pwdata[4] |-> ##3 !irq [*3])
		else $error("interrupt during soft reset");
	cover property (wc1 && pwdata[4]);
	cover property (pslverr);
	cover property ($rose(irq));
endmodule

bind rtcc_ctrl rtcc_ctrl_asserts #(.SEC_CYC(SEC_CYC), .BUSY_CYC(BUSY_CYC))
	rtcc_ctrl_asserts_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: rtcc_tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_consts.vh"

module tb;
	localparam [31:0] SEC = 32'h4;            // Shortened second
	localparam [7:0]  BSY = 8'h2;             // Shortened busy period
	localparam [19:0] C1 = `RTCC_CTRL1_ADDR;  // Control one
	localparam [19:0] C2 = `RTCC_CTRL2_ADDR;  // Control two
	localparam [19:0] TM = `RTCC_TIME_ADDR;   // Time readback
	localparam [19:0] ST = `RTCC_STAT_ADDR;   // Event status
	localparam [19:0] CL = `RTCC_CLR_ADDR;    // Status clear
	localparam [19:0] EN = `RTCC_IEN_ADDR;    // Event enable
	reg         core_clk;
	reg         arst_n;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg  [19:0] paddr;
	reg  [31:0] pwdata;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        irq;
	reg  [31:0] rdv;         // Last read data
	reg         erv;         // Last error flag
	reg  [31:0] t1;          // Frozen time
	integer     n_mismatch;
	integer     compares;
	integer     cyc;         // Cycles run, for the timeout
	integer     d0;          // Event delay, timing bit 0
	integer     d1;          // Event delay, timing bit 1

	rtcc_ctrl #(.SEC_CYC(SEC), .BUSY_CYC(BSY)) rtcc_ctrl_inst (
		.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));

	// Clock, 4 ns period
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// One bus transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge core_clk);
			penable <= 1'b1;
			@(posedge core_clk);
			// Wait for the answer; only the bench timeout ends a hang
			while (pready !== 1'b1)
			begin
				@(posedge core_clk);
			end
			rdv = prdata;
			erv = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge core_clk);
		end
	endtask

	task wr(input logic [19:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [19:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// Compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		begin
			compares = compares + 1;
			if (s !== e)
			begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected %s: expected %h, seen %h", nm, e, s);
			end
		end
	endtask

	// From a soft reset, cycles until the one-second event interrupts
	task meas(input logic [7:0] c, output integer n);
		begin
			wr(C1, 32'h10);
			wr(C1, 32'h0);
			wr(C2, 32'h4);
			wr(EN, 32'h1);
			wr(C1, {24'h0, c});
			n = 0;
			while (irq !== 1'b1 && n < 100)
			begin
				@(posedge core_clk);
				n = n + 1;
			end
		end
	endtask

	task end_of_test;
		begin
			$display("compares %0d, mismatches %0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	// Timeout; the run needs well under 3000 cycles
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch = n_mismatch + 1;
			end_of_test;
		end
	end

	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h0;
		pwdata = 32'h0;
		n_mismatch = 0;
		compares = 0;
		cyc = 0;
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(C1);
		chk("ctrl1 reset", 32'h0, rdv);
		rd(C2);
		chk("ctrl2 reset", 32'h0, rdv);
		rd(TM);
		chk("time reset", 32'h0, rdv);
		wr(ST, 32'hf);
		rd(ST);
		chk("status read-only", 32'h0, rdv);
		rd(EN);
		chk("enable reset", 32'h0, rdv);
		rd(20'h3c1d0);
		chk("unmapped error", 32'h1, {31'h0, erv});
		wr(C1, 32'h48);
		rd(C1);
		chk("ctrl1 format", 32'h48, rdv);
		$display("test registers done");
		meas(8'h80, d0);
		meas(8'h88, d1);
		chk("event delay", {24'h0, BSY}, d1 - d0);
		rd(ST);
		chk("second event", 32'h1, rdv & 32'h1);
		$display("test timing done");
		wr(C1, 32'h10);
		rd(TM);
		chk("time soft reset", 32'h0, rdv);
		rd(ST);
		chk("status soft reset", 32'h0, rdv);
		rd(C2);
		chk("ctrl2 soft reset", 32'h0, rdv);
		rd(C1);
		chk("ctrl1 soft reset", 32'h10, rdv);
		wr(C1, 32'h0);
		rd(C1);
		chk("ctrl1 release", 32'h0, rdv);
		$display("test soft reset done");
		wr(EN, 32'hf);
		wr(C1, 32'h80);
		repeat (40) @(posedge core_clk);
		rd(ST);
		chk("second masked", 32'h0, rdv & 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(C2, 32'h4);
		repeat (20) @(posedge core_clk);
		rd(ST);
		chk("second on", 32'h1, rdv & 32'h1);
		chk("irq on", 32'h1, {31'h0, irq});
		$display("test second enable done");
		repeat (240) @(posedge core_clk);
		wr(C1, 32'h0);
		rd(TM);
		t1 = rdv;
		chk("minute count", 32'h1, {26'h0, t1[13:8]});
		rd(ST);
		chk("minute event", 32'h2, rdv & 32'h2);
		wr(EN, 32'h0);
		chk("irq disabled", 32'h0, {31'h0, irq});
		wr(EN, 32'hf);
		chk("irq enabled", 32'h1, {31'h0, irq});
		wr(CL, 32'hf);
		repeat (60) @(posedge core_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(TM);
		chk("time held", t1, rdv);
		rd(ST);
		chk("no events stopped", 32'h0, rdv);
		$display("test stop done");
		end_of_test;
	end
endmodule
`default_nettype wire
